// ==== sfsio_clr_qual.sv ====
`timescale 1ns/1ns
module sfsio_clr_qual #(
  parameter int TICK_CYCLES  = sfsio_pkg::TICK_CYCLES,
  parameter int CLEAR_MIN_MS = sfsio_pkg::CLEAR_MIN_MS
) (
  input  wire logic i_clk,     // system clock
  input  wire logic i_arst_n,  // async reset, active low
  input  wire logic i_level,   // raw clear input
  output logic      o_accept   // one-cycle accepted clear
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int MW = $clog2(CLEAR_MIN_MS + 1);

  logic          sync1_q;
  logic          sync2_q;
  logic [PW-1:0] pre_q;
  logic [PW-1:0] pre_d;
  logic [MW-1:0] ms_q;
  logic [MW-1:0] ms_d;
  logic          done_q;
  logic          done_d;
  logic          acc_q;

  // ----------------------------------------------------------------
  // high-time measurement
  // ----------------------------------------------------------------
  wire tick     = (pre_q == PW'(TICK_CYCLES - 1));
  wire last_ms  = (ms_q == MW'(CLEAR_MIN_MS - 1));
  wire hit      = sync2_q && !done_q && tick && last_ms;

  assign pre_d  = (!sync2_q || done_q || tick) ? '0 : pre_q + PW'(1);
  assign ms_d   = !sync2_q ? '0 : (tick && !done_q) ? ms_q + MW'(1) : ms_q;
  assign done_d = sync2_q && (done_q || hit);
  assign o_accept = acc_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      pre_q   <= '0;
      ms_q    <= '0;
      done_q  <= 1'b0;
      acc_q   <= 1'b0;
    end
    else
    begin
      sync1_q <= i_level;     // see RQ10
      sync2_q <= sync1_q;     // see RQ10
      pre_q   <= pre_d;
      ms_q    <= ms_d;
      done_q  <= done_d;
      acc_q   <= hit;         // see RQ10
    end
  end

endmodule

// ==== sfsio_mains_hold.sv ====
`timescale 1ns/1ns
module sfsio_mains_hold #(
  parameter int TICK_CYCLES   = sfsio_pkg::TICK_CYCLES,
  parameter int MAINS_HOLD_MS = sfsio_pkg::MAINS_HOLD_MS
) (
  input  wire logic i_clk,     // system clock
  input  wire logic i_arst_n,  // async reset, active low
  input  wire logic i_ac,      // valid ac detected
  output logic      o_present  // ac present with dropout delay
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int MW = $clog2(MAINS_HOLD_MS + 1);

  logic          pres_q;
  logic [PW-1:0] pre_q;
  logic [MW-1:0] ms_q;

  // ----------------------------------------------------------------
  // off delay, restarted on each loss
  // ----------------------------------------------------------------
  wire tick    = (pre_q == PW'(TICK_CYCLES - 1));
  wire expire  = !i_ac && pres_q && tick && (ms_q == MW'(MAINS_HOLD_MS - 1));
  wire pres_d  = i_ac || (pres_q && !expire);
  wire [PW-1:0] pre_d = (i_ac || !pres_q || tick) ? '0 : pre_q + PW'(1);
  wire [MW-1:0] ms_d  = (i_ac || !pres_q) ? '0 : tick ? ms_q + MW'(1) : ms_q;

  assign o_present = pres_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pres_q <= 1'b0;
      pre_q  <= '0;
      ms_q   <= '0;
    end
    else
    begin
      pres_q <= pres_d;  // see RQ5
      pre_q  <= pre_d;
      ms_q   <= ms_d;
    end
  end

endmodule

// ==== sfsio_partner.sv ====
`timescale 1ns/1ns
module sfsio_partner (
  input  wire logic       i_clk,       // system clock
  input  wire logic       i_arst_n,    // async reset, active low
  input  wire logic       i_permit,    // run permit contact, closed high
  input  wire logic       i_outage,    // mains outage command
  input  wire logic       i_clr_go,    // start a clear pulse
  input  wire logic [7:0] i_clr_len,   // clear pulse length in cycles
  output logic            o_ac_valid,  // mains behind the contactor
  output logic            o_clear      // fault clear drive
);
  logic [1:0] coil_q;
  logic [7:0] pulse_q;

  // contactor pulls in two cycles after the contact closes
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      coil_q  <= 2'h0;
      pulse_q <= 8'h00;
    end
    else
    begin
      coil_q  <= {coil_q[0], i_permit};
      pulse_q <= i_clr_go ? i_clr_len : ((pulse_q != 8'h00) ? pulse_q - 8'h01 : 8'h00);
    end
  end

  assign o_ac_valid = coil_q[1] & ~i_outage;
  assign o_clear    = (pulse_q != 8'h00);  // held for the whole commanded count
endmodule

// ==== sfsio_pkg.sv ====
package sfsio_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int CLEAR_MIN_MS  = 100;
  localparam int MAINS_HOLD_MS = 20;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_ALARMS = 4;
  localparam int AW         = 4;
  localparam int DW         = 32;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL   = 4'h0;
  localparam logic [AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [AW-1:0] OFS_CAUSE  = 4'h8;

  // ctrl fields
  localparam int CTRL_SOFT_CLR_BIT = 0;
  localparam int CTRL_HOLD_BIT     = 1;
  localparam logic CTRL_HOLD_RESET = 1'b0;

  // status fields
  localparam int ST_DCOK_BIT    = 0;
  localparam int ST_MAINS_BIT   = 1;
  localparam int ST_FAULT_BIT   = 2;
  localparam int ST_PERMIT_BIT  = 3;
  localparam int ST_ENABLE_BIT  = 4;
  localparam int ST_CHARGED_BIT = 5;
  localparam int ST_STATE_LSB   = 8;

  localparam logic [DW-1:0] CAUSE_RESET = 32'h0;

  // ----------------------------------------------------------------
  // supply states, gray along idle-charge-run-fault
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFSIO_IDLE   = 2'b00,
    SFSIO_CHARGE = 2'b01,
    SFSIO_RUN    = 2'b11,
    SFSIO_FAULT  = 2'b10
  } sfsio_state_t;

endpackage

// ==== sfsio_top.sv ====
// Operation
// RQ1: controller holds the clear input high at least 100 ms.
// RQ2: accepted clear starts a new restore attempt, re-enabling the dc bus.
// RQ3: dc bus ok output only in operative state without fault.
// RQ4: reported fault opens the run permit contact and drops dc bus ok.
// RQ5: mains present follows valid ac, drops about 20 ms after loss.
// RQ6: detected fault lights the fault output and disables the dc bus.
// RQ7: with logic supplied and no alarm, run permit contact closes. The code keeps it open in the fault state until a clear is accepted.
// RQ8: any alarm opens the run permit contact.
// RQ9: one clear input, three status outputs: bus ready, mains, fault.
// RQ10: clear input is synchronised and its high time measured in ms.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module sfsio_top #(
  parameter int TICK_CYCLES   = sfsio_pkg::TICK_CYCLES,
  parameter int CLEAR_MIN_MS  = sfsio_pkg::CLEAR_MIN_MS,
  parameter int MAINS_HOLD_MS = sfsio_pkg::MAINS_HOLD_MS,
  parameter int NUM_ALARMS    = sfsio_pkg::NUM_ALARMS
) (
  input  wire logic                      i_clk,                     // system clock
  input  wire logic                      i_arst_n,                  // async reset, active low
  input  wire logic                      i_fault_clear_input,       // fault clear pin
  input  wire logic                      i_ac_valid,                // valid ac mains detected
  input  wire logic [NUM_ALARMS-1:0]     i_alarm,                   // alarm sources, high active
  input  wire logic                      i_dc_bus_charged,          // dc bus reached voltage
  input  wire logic [sfsio_pkg::AW-1:0]  i_avs_address,             // byte address
  input  wire logic                      i_avs_read,                // read request
  input  wire logic                      i_avs_write,               // write request
  input  wire logic [sfsio_pkg::DW-1:0]  i_avs_writedata,           // write data
  input  wire logic [3:0]                i_avs_byteenable,          // byte enables
  output logic      [sfsio_pkg::DW-1:0]  o_avs_readdata,            // read data
  output logic                           o_avs_waitrequest,         // stall
  output logic                           o_dc_bus_ok_output,        // dc bus ready
  output logic                           o_mains_present_output,    // mains present
  output logic                           o_fault_indicator_output,  // fault
  output logic                           o_run_permit_contact,      // contactor permit, closed high
  output logic                           o_dc_bus_enable            // generate dc bus voltage
);

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  logic clr_hw;
  logic mains_pres;

  sfsio_clr_qual #(
    .TICK_CYCLES  (TICK_CYCLES),
    .CLEAR_MIN_MS (CLEAR_MIN_MS)
  ) u_clr (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_level  (i_fault_clear_input),
    .o_accept (clr_hw)
  );

  sfsio_mains_hold #(
    .TICK_CYCLES   (TICK_CYCLES),
    .MAINS_HOLD_MS (MAINS_HOLD_MS)
  ) u_mains (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_ac      (i_ac_valid),
    .o_present (mains_pres)
  );

  // ----------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ----------------------------------------------------------------
  logic                     ack_q;
  logic                     hold_q;
  logic                     soft_clr_q;
  logic [NUM_ALARMS-1:0]    cause_q;
  logic [sfsio_pkg::DW-1:0] rdata_q;
  logic [sfsio_pkg::DW-1:0] status_word;
  logic [sfsio_pkg::DW-1:0] rd_mux;

  wire bus_req   = i_avs_read || i_avs_write;
  wire ack_d     = bus_req && !ack_q;
  wire wr_take   = i_avs_write && ack_q;
  wire sel_ctrl  = (i_avs_address == sfsio_pkg::OFS_CTRL);
  wire sel_stat  = (i_avs_address == sfsio_pkg::OFS_STATUS);
  wire sel_cause = (i_avs_address == sfsio_pkg::OFS_CAUSE);
  wire wr_ctrl   = wr_take && sel_ctrl && i_avs_byteenable[0];
  wire soft_clr_d = wr_ctrl && i_avs_writedata[sfsio_pkg::CTRL_SOFT_CLR_BIT];
  wire hold_d    = wr_ctrl ? i_avs_writedata[sfsio_pkg::CTRL_HOLD_BIT] : hold_q;

  assign o_avs_waitrequest = bus_req && !ack_q;
  assign o_avs_readdata    = rdata_q;

  // ----------------------------------------------------------------
  // supply state machine
  // ----------------------------------------------------------------
  sfsio_pkg::sfsio_state_t state_q;
  sfsio_pkg::sfsio_state_t state_d;

  wire alarm_any = |i_alarm;
  wire clear_req = clr_hw || soft_clr_q;
  wire start_ok  = mains_pres && !hold_q;
  wire [NUM_ALARMS-1:0] cause_d = (cause_q & ~{NUM_ALARMS{clear_req}}) | i_alarm;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sfsio_pkg::SFSIO_IDLE:
        if (start_ok)
          state_d = sfsio_pkg::SFSIO_CHARGE;
      sfsio_pkg::SFSIO_CHARGE:
        if (!start_ok)
          state_d = sfsio_pkg::SFSIO_IDLE;
        else if (i_dc_bus_charged)
          state_d = sfsio_pkg::SFSIO_RUN;
      sfsio_pkg::SFSIO_RUN:
        if (!start_ok || !i_dc_bus_charged)
          state_d = sfsio_pkg::SFSIO_IDLE;
      sfsio_pkg::SFSIO_FAULT:
        if (clear_req)                                        // see RQ2
          state_d = start_ok ? sfsio_pkg::SFSIO_CHARGE : sfsio_pkg::SFSIO_IDLE;
      default:
        state_d = sfsio_pkg::SFSIO_IDLE;
    endcase
    if (alarm_any)
      state_d = sfsio_pkg::SFSIO_FAULT;                       // see RQ6
  end

  // ----------------------------------------------------------------
  // output decode, registered
  // ----------------------------------------------------------------
  wire dcok_d   = (state_d == sfsio_pkg::SFSIO_RUN);                     // see RQ3
  wire fault_d  = (state_d == sfsio_pkg::SFSIO_FAULT);                   // see RQ6
  wire permit_d = !fault_d && !alarm_any;                                // see RQ7, see RQ8
  wire enable_d = (state_d == sfsio_pkg::SFSIO_CHARGE) || dcok_d;       // see RQ2

  logic dcok_q;
  logic fault_q;
  logic permit_q;
  logic enable_q;

  assign o_dc_bus_ok_output       = dcok_q;      // see RQ9
  assign o_mains_present_output   = mains_pres;  // see RQ9
  assign o_fault_indicator_output = fault_q;     // see RQ9
  assign o_run_permit_contact     = permit_q;
  assign o_dc_bus_enable          = enable_q;

  always_comb
  begin
    status_word = '0;
    status_word[sfsio_pkg::ST_DCOK_BIT]    = dcok_q;
    status_word[sfsio_pkg::ST_MAINS_BIT]   = mains_pres;
    status_word[sfsio_pkg::ST_FAULT_BIT]   = fault_q;
    status_word[sfsio_pkg::ST_PERMIT_BIT]  = permit_q;
    status_word[sfsio_pkg::ST_ENABLE_BIT]  = enable_q;
    status_word[sfsio_pkg::ST_CHARGED_BIT] = i_dc_bus_charged;
    status_word[sfsio_pkg::ST_STATE_LSB +: 2] = state_q;
  end

  always_comb
  begin
    rd_mux = '0;
    if (sel_ctrl)
      rd_mux[sfsio_pkg::CTRL_HOLD_BIT] = hold_q;
    else if (sel_stat)
      rd_mux = status_word;
    else if (sel_cause)
      rd_mux[NUM_ALARMS-1:0] = cause_q;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q  <= sfsio_pkg::SFSIO_IDLE;
      dcok_q   <= 1'b0;
      fault_q  <= 1'b0;
      permit_q <= 1'b0;
      enable_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      dcok_q   <= dcok_d;
      fault_q  <= fault_d;
      permit_q <= permit_d;   // see RQ4
      enable_q <= enable_d;   // see RQ6
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ack_q      <= 1'b0;
      hold_q     <= sfsio_pkg::CTRL_HOLD_RESET;
      soft_clr_q <= 1'b0;
      cause_q    <= sfsio_pkg::CAUSE_RESET[NUM_ALARMS-1:0];
      rdata_q    <= '0;
    end
    else
    begin
      ack_q      <= ack_d;
      hold_q     <= hold_d;
      soft_clr_q <= soft_clr_d;
      cause_q    <= cause_d;
      rdata_q    <= ack_d ? rd_mux : rdata_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_restore;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_q == sfsio_pkg::SFSIO_FAULT && clear_req && !alarm_any && start_ok) |=> o_dc_bus_enable;
  endproperty
  a_restore: assert property (p_restore) else $error("clear did not restart dc bus"); // see RQ2

  property p_bus_ok;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_dc_bus_ok_output |-> (state_q == sfsio_pkg::SFSIO_RUN) && !o_fault_indicator_output && o_dc_bus_enable;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus ok outside operative state"); // see RQ3

  property p_fault_opens;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_fault_indicator_output |-> !o_run_permit_contact && !o_dc_bus_ok_output;
  endproperty
  a_fault_opens: assert property (p_fault_opens) else $error("fault with permit or bus ok"); // see RQ4

  property p_mains_on;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_ac_valid |=> o_mains_present_output;
  endproperty
  a_mains_on: assert property (p_mains_on) else $error("mains present missing"); // see RQ5

  property p_mains_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    ($fell(i_ac_valid) && o_mains_present_output) |=> o_mains_present_output [*4];
  endproperty
  a_mains_hold: assert property (p_mains_hold) else $error("mains dropped without delay"); // see RQ5

  property p_fault_on;
    @(posedge i_clk) disable iff (!i_arst_n)
    alarm_any |=> o_fault_indicator_output && !o_dc_bus_enable;
  endproperty
  a_fault_on: assert property (p_fault_on) else $error("alarm not reported as fault"); // see RQ6

  property p_permit_close;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!alarm_any && state_q != sfsio_pkg::SFSIO_FAULT) ##1 (!alarm_any && $stable(state_q)) |-> o_run_permit_contact;
  endproperty
  a_permit_close: assert property (p_permit_close) else $error("permit not closed"); // see RQ7

  property p_permit_open;
    @(posedge i_clk) disable iff (!i_arst_n)
    alarm_any |=> !o_run_permit_contact;
  endproperty
  a_permit_open: assert property (p_permit_open) else $error("permit closed during alarm"); // see RQ8

  property p_exclusive;
    @(posedge i_clk) disable iff (!i_arst_n)
    !(o_dc_bus_ok_output && o_fault_indicator_output);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("ready and fault together"); // see RQ9

  property p_clear_pulse;
    @(posedge i_clk) disable iff (!i_arst_n)
    clr_hw |-> $past(i_fault_clear_input, 2) ##1 !clr_hw;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear accepted without high input"); // see RQ10

  c_fault:   cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_fault_indicator_output));
  c_restore: cover property (@(posedge i_clk) disable iff (!i_arst_n)
                             state_q == sfsio_pkg::SFSIO_FAULT && clear_req ##1 o_dc_bus_enable);
  c_run:     cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_dc_bus_ok_output));
  c_drop:    cover property (@(posedge i_clk) disable iff (!i_arst_n) $fell(o_mains_present_output));

endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
`define SFSIO_CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  localparam int         TICK    = 4;
  localparam int         CLR_MS  = 3;
  localparam int         HOLD_MS = 3;
  localparam int         HOLD    = HOLD_MS * TICK;
  localparam logic [7:0] FULL    = 8'(CLR_MS * TICK + 4);
  localparam logic [7:0] SHORT   = 8'(CLR_MS * TICK - 2);
  localparam logic [4:0] CHG     = 5'h0b;
  localparam logic [4:0] RUN     = 5'h1b;
  localparam logic [4:0] FLT     = 5'h04;
  localparam logic [4:0] IDL     = 5'h0a;

  typedef struct packed {logic [3:0] alarm; logic [7:0] clr; logic [4:0] exp;} sfsio_row_t;

  logic        clk, arst_n, clr_pin, ac_valid, charged, avs_rd, avs_wr, waitreq, outage, clr_go;
  logic        ok, mains, fault, permit, en;
  logic [3:0]  alarm, avs_addr, avs_be;
  logic [7:0]  clr_len;
  logic [31:0] avs_wd, rdata;
  logic [4:0]  outs;
  int          error_cnt, check_count;

  // outputs in order: ok, mains, fault, permit, dc enable
  assign outs = {ok, mains, fault, permit, en};

  sfsio_row_t rows [12] = '{
    '{4'h0, 8'h00, RUN}, '{4'h1, 8'h00, FLT}, '{4'h1, FULL, FLT}, '{4'h0, 8'h00, FLT},
    '{4'h0, SHORT, FLT}, '{4'h0, FULL, RUN}, '{4'h2, 8'h00, FLT}, '{4'h0, FULL, RUN},
    '{4'h4, 8'h00, FLT}, '{4'h0, FULL, RUN}, '{4'h8, 8'h00, FLT}, '{4'h0, FULL, RUN}};

  sfsio_top #(.TICK_CYCLES(TICK), .CLEAR_MIN_MS(CLR_MS), .MAINS_HOLD_MS(HOLD_MS)) u_sfsio_top (
    .i_clk(clk), .i_arst_n(arst_n), .i_fault_clear_input(clr_pin), .i_ac_valid(ac_valid),
    .i_alarm(alarm), .i_dc_bus_charged(charged), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
    .i_avs_write(avs_wr), .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_dc_bus_ok_output(ok),
    .o_mains_present_output(mains), .o_fault_indicator_output(fault),
    .o_run_permit_contact(permit), .o_dc_bus_enable(en));

  sfsio_partner u_sfsio_partner (
    .i_clk(clk), .i_arst_n(arst_n), .i_permit(permit), .i_outage(outage), .i_clr_go(clr_go),
    .i_clr_len(clr_len), .o_ac_valid(ac_valid), .o_clear(clr_pin));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task final_report();
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
          output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_addr <= a;
    avs_wd   <= d;
    avs_be   <= be;
    avs_wr   <= wr;
    avs_rd   <= ~wr;
    n = 0;
    // waitrequest and read data sampled at the rising edge itself
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    av(1'b1, a, d, be, q);
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, 4'hf, q);
    `SFSIO_CHK(q, exp)
  endtask

  // waits for the expected outputs, then checks them once more 40 cycles later
  task settle(input logic [4:0] exp);
    int n;
    n = 0;
    while (outs !== exp && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (40) @(posedge clk);
    #1;
    `SFSIO_CHK(outs, exp)
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int   n;
    logic dip;
    {arst_n, alarm, charged, avs_rd, avs_wr, outage, clr_go} = '0;
    {avs_addr, avs_be, avs_wd, clr_len} = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    #1;
    `SFSIO_CHK({outs, waitreq}, 6'h00)
    @(posedge clk);
    arst_n <= 1'b1;
    settle(CHG);
    @(posedge clk);
    charged <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      alarm <= rows[i].alarm;
      if (rows[i].clr != 8'h00)
      begin
        clr_len <= rows[i].clr;
        clr_go  <= 1'b1;
        @(posedge clk);
        clr_go  <= 1'b0;
      end
      settle(rows[i].exp);
    end
    @(posedge clk);
    outage <= 1'b1;
    n = 0;
    while (mains === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `SFSIO_CHK(n >= HOLD && n <= HOLD + 3, 1'b1)
    settle(5'h02);
    @(posedge clk);
    outage <= 1'b0;
    settle(RUN);
    @(posedge clk);
    outage <= 1'b1;
    dip = 1'b0;
    repeat (HOLD - 4)
    begin
      @(posedge clk);
      #1;
      dip |= (outs !== RUN);
    end
    @(posedge clk);
    outage <= 1'b0;
    `SFSIO_CHK(dip, 1'b0)
    rd_chk(sfsio_pkg::OFS_STATUS, 32'h33b);
    rd_chk(4'hc, 32'h0);
    rd_chk(sfsio_pkg::OFS_CTRL, 32'h0);
    wr(sfsio_pkg::OFS_CTRL, 32'h2, 4'hf);
    settle(IDL);
    rd_chk(sfsio_pkg::OFS_STATUS, 32'h2a);
    wr(sfsio_pkg::OFS_CTRL, 32'h0, 4'h0);
    rd_chk(sfsio_pkg::OFS_CTRL, 32'h2);
    wr(sfsio_pkg::OFS_CTRL, 32'h0, 4'hf);
    settle(RUN);
    @(posedge clk);
    alarm <= 4'h4;
    settle(FLT);
    @(posedge clk);
    alarm <= 4'h0;
    rd_chk(sfsio_pkg::OFS_CAUSE, 32'h4);
    wr(sfsio_pkg::OFS_CTRL, 32'h1, 4'hf);
    settle(RUN);
    // short alarm, cleared while mains is still held: restore goes straight to charge
    @(posedge clk);
    alarm <= 4'h2;
    @(posedge clk);
    alarm <= 4'h0;
    wr(sfsio_pkg::OFS_CTRL, 32'h1, 4'hf);
    settle(RUN);
    // losing the charged bus in run falls back through idle to charge
    @(posedge clk);
    charged <= 1'b0;
    settle(CHG);
    @(posedge clk);
    charged <= 1'b1;
    settle(RUN);
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    `SFSIO_CHK(outs, 5'h00)
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    settle(RUN);
    final_report();
  end
endmodule
